// *** src/ftis_pkg.sv ***
// Purpose: Shared constants and carriers for the dual frame timer block.
// Assumes: Registers sit on classic Wishbone with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package ftis_pkg;
   localparam logic [7:0] FTIS_CTRL_OFS = 8'h00;
   localparam logic [7:0] FTIS_PEND_OFS = 8'h04;
   localparam logic [7:0] FTIS_ALLOW_OFS = 8'h08;
   localparam logic [7:0] FTIS_STAT_OFS = 8'h0C;
   localparam logic [7:0] FTIS_TMR0_OFS = 8'h20;
   localparam logic [7:0] FTIS_TMR1_OFS = 8'h40;
   localparam int FTIS_CFG_WORDS = 7;
   localparam logic [2:0] FTIS_STAT_IDX = 3'h7;
   localparam int FTIS_CTRL_EN0 = 0;
   localparam int FTIS_CTRL_EN1 = 1;
   localparam int FTIS_CTRL_LOCK = 2;
   localparam int FTIS_CTRL_ILACE = 3;
   localparam int FTIS_CTRL_MODE0 = 4;
   localparam int FTIS_CTRL_MODE1 = 6;
   localparam int FTIS_PEND_T0 = 8;
   localparam int FTIS_PEND_T1 = 9;
   localparam int FTIS_ALLOW_GLB = 0;
   localparam logic [7:0] FTIS_CTRL_RST = 8'h00;
   localparam logic [31:0] FTIS_CFG_RST = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      FTIS_MODE_DISPLAY = 2'b00,
      FTIS_MODE_CAPTURE = 2'b01,
      FTIS_MODE_MERGE = 2'b10
   } ftis_mode_t;

   typedef struct packed
   {
      logic [15:0] hcnt;
      logic [15:0] vcnt;
      logic field;
      logic hsync;
      logic hblank;
      logic vsync;
      logic vblank;
      logic cblank_n;
      logic area;
      logic xreq;
      logic xframe;
   } ftis_tmr_t;

   typedef struct packed
   {
      logic hsync;
      logic hblank;
      logic vsync;
      logic vblank;
      logic cblank_n;
      logic area;
      logic field;
   } ftis_video_t;

   typedef struct packed
   {
      logic req;
      logic frame_start;
      logic to_memory;
      logic keep_outside;
   } ftis_xfer_t;
endpackage

// *** src/ftis_frame_timers.sv ***
// Purpose: Two frame timers with sync, blanking, area, transfer events
//          and interrupt pending and allow registers on Wishbone.
// Assumes: The video timing clock is a pin sampled by clk_i.
// Notes: Counters advance once per rising edge of the timing clock.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ftis_frame_timers
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic video_timing_clock_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [1:0] irq_o,
   output logic service_o,
   output ftis_pkg::ftis_video_t [1:0] video_o,
   output ftis_pkg::ftis_xfer_t [1:0] xfer_o
);
   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [1:0] pend;
      logic [2:0] allow;
      logic [1:0][ftis_pkg::FTIS_CFG_WORDS-1:0][31:0] cfg;
      ftis_pkg::ftis_tmr_t [1:0] tm;
      logic [2:0] sync;
      logic ack;
      logic [31:0] dat;
   } ftis_state_t;

   ftis_state_t state_q;
   ftis_state_t state_d;
   logic tick;
   logic wr;
   logic tsel;
   logic tacc;
   logic [2:0] tidx;
   logic [1:0] en;
   logic ilace;
   logic [1:0] pend_set;
   logic [1:0] pend_clr;
   logic [31:0] word;
   logic [15:0] nh;
   logic [15:0] nv;
   logic [15:0] half;
   logic [15:0] line;
   logic hwrap;
   logic vstep;
   logic vwrap;
   logic [1:0][15:0] htot;
   logic [1:0][15:0] vtot;

   always_comb
   begin
      state_d = state_q;
      word = 32'h0000_0000;
      nh = 16'h0000;
      nv = 16'h0000;
      half = 16'h0000;
      line = 16'h0000;
      hwrap = 1'b0;
      vstep = 1'b0;
      vwrap = 1'b0;
      pend_set = 2'b00;
      pend_clr = 2'b00;
      en = {state_q.ctrl[ftis_pkg::FTIS_CTRL_EN1],
            state_q.ctrl[ftis_pkg::FTIS_CTRL_EN0]};
      ilace = state_q.ctrl[ftis_pkg::FTIS_CTRL_ILACE];
      state_d.sync = {state_q.sync[1:0], video_timing_clock_i};
      tick = state_q.sync[1] & ~state_q.sync[2];
      // Bus decode; writes land on the edge where ack is seen.
      state_d.ack = wb_cyc_i & wb_stb_i & ~state_q.ack;
      wr = wb_cyc_i & wb_stb_i & wb_we_i & state_q.ack;
      tacc = ~wb_adr_i[7] & (wb_adr_i[6] ^ wb_adr_i[5]);
      tsel = wb_adr_i[6];
      tidx = wb_adr_i[4:2];
      if (tacc)
      begin
         if (tidx == ftis_pkg::FTIS_STAT_IDX)
         begin
            word = {state_q.tm[tsel].vcnt, state_q.tm[tsel].hcnt};
         end
         else
         begin
            word = state_q.cfg[tsel][tidx];
         end
      end
      else if (wb_adr_i == ftis_pkg::FTIS_CTRL_OFS)
      begin
         word = {24'h00_0000, state_q.ctrl};
      end
      else if (wb_adr_i == ftis_pkg::FTIS_PEND_OFS)
      begin
         word = {22'h00_0000, state_q.pend, 8'h00};
      end
      else if (wb_adr_i == ftis_pkg::FTIS_ALLOW_OFS)
      begin
         word = {22'h00_0000, state_q.allow[2:1], 7'h00,
                 state_q.allow[0]};
      end
      else if (wb_adr_i == ftis_pkg::FTIS_STAT_OFS)
      begin
         word = {28'h000_0000, state_q.tm[1].field, state_q.tm[0].field,
                 state_q.pend};
      end
      if (state_d.ack)
      begin
         state_d.dat = word;
      end
      if (wr)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b])
            begin
               word[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
         end
         if (tacc && tidx != ftis_pkg::FTIS_STAT_IDX)
         begin
            state_d.cfg[tsel][tidx] = word;
         end
         else if (wb_adr_i == ftis_pkg::FTIS_CTRL_OFS)
         begin
            state_d.ctrl = word[7:0];
         end
         else if (wb_adr_i == ftis_pkg::FTIS_PEND_OFS)
         begin
            pend_clr = wb_dat_i[ftis_pkg::FTIS_PEND_T1:
                                ftis_pkg::FTIS_PEND_T0] & {2{wb_sel_i[1]}};
         end
         else if (wb_adr_i == ftis_pkg::FTIS_ALLOW_OFS)
         begin
            state_d.allow = {word[ftis_pkg::FTIS_PEND_T1:
                                  ftis_pkg::FTIS_PEND_T0],
                             word[ftis_pkg::FTIS_ALLOW_GLB]};
         end
      end
      for (int t = 0; t < 2; t++)
      begin
         htot[t] = state_q.cfg[t][0][15:0];
         vtot[t] = state_q.cfg[t][2][15:0];
         state_d.tm[t].xreq = 1'b0;
         state_d.tm[t].xframe = 1'b0;
         if (!en[t])
         begin
            state_d.tm[t].hcnt = 16'h0000;
            state_d.tm[t].vcnt = 16'h0000;
            state_d.tm[t].field = 1'b0;
         end
         else if (tick)
         begin
            hwrap = state_q.tm[t].hcnt == htot[t];
            nh = hwrap ? 16'h0000 : state_q.tm[t].hcnt + 16'h0001;
            half = 16'((17'(htot[t]) + 17'h0_0001) >> 1);
            // Vertical count in lines or half lines
            vstep = hwrap | (ilace & (nh == half));
            nv = state_q.tm[t].vcnt;
            if (vstep)
            begin
               vwrap = state_q.tm[t].vcnt == vtot[t];
               nv = vwrap ? 16'h0000 : state_q.tm[t].vcnt + 16'h0001;
               state_d.tm[t].xframe = vwrap;
               state_d.tm[t].field = ilace & (state_q.tm[t].field ^ vwrap);
            end
            state_d.tm[t].hcnt = nh;
            state_d.tm[t].vcnt = nv;
            state_d.tm[t].hsync = nh <= state_q.cfg[t][0][31:16];
            state_d.tm[t].hblank = (nh >= state_q.cfg[t][1][31:16]) |
                                   (nh <= state_q.cfg[t][1][15:0]);
            state_d.tm[t].vsync = nv <= state_q.cfg[t][2][31:16];
            state_d.tm[t].vblank = (nv >= state_q.cfg[t][3][31:16]) |
                                   (nv <= state_q.cfg[t][3][15:0]);
            state_d.tm[t].cblank_n = ~(state_d.tm[t].hblank |
                                       state_d.tm[t].vblank);
            line = ilace ? (nv >> 1) : nv;
            state_d.tm[t].area = (nh >= state_q.cfg[t][4][15:0]) &
                                 (nh <= state_q.cfg[t][4][31:16]) &
                                 (line >= state_q.cfg[t][5][15:0]) &
                                 (line <= state_q.cfg[t][5][31:16]);
            state_d.tm[t].xreq = state_d.tm[t].xframe |
                                 ((nh == state_q.cfg[t][6][31:16]) &
                                  ~state_d.tm[t].vblank);
            pend_set[t] = hwrap & (nv == state_q.cfg[t][6][15:0]);
         end
         if (!ilace)
         begin
            state_d.tm[t].field = 1'b0;
         end
      end
      if (state_q.ctrl[ftis_pkg::FTIS_CTRL_LOCK] && en[1] &&
          state_d.tm[0].xframe)
      begin
         state_d.tm[1].hcnt = 16'h0000;
         state_d.tm[1].vcnt = 16'h0000;
         state_d.tm[1].field = state_d.tm[0].field;
         state_d.tm[1].xframe = 1'b1;
         state_d.tm[1].xreq = 1'b1;
      end
      state_d.pend = (state_q.pend & ~pend_clr) | pend_set;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= '0;
         state_q.ctrl <= ftis_pkg::FTIS_CTRL_RST;
         state_q.cfg <= {(2 * ftis_pkg::FTIS_CFG_WORDS)
                         {ftis_pkg::FTIS_CFG_RST}};
         state_q.tm[0].cblank_n <= 1'b1;
         state_q.tm[1].cblank_n <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign wb_dat_o = state_q.dat;
   assign wb_ack_o = state_q.ack;
   assign irq_o = state_q.pend;
   assign service_o = state_q.allow[0] & |(state_q.pend & state_q.allow[2:1]);

   for (genvar g = 0; g < 2; g++)
   begin : g_out
      localparam int ML = g ? ftis_pkg::FTIS_CTRL_MODE1
                            : ftis_pkg::FTIS_CTRL_MODE0;
      assign video_o[g] = {state_q.tm[g].hsync, state_q.tm[g].hblank,
                           state_q.tm[g].vsync, state_q.tm[g].vblank,
                           state_q.tm[g].cblank_n, state_q.tm[g].area,
                           state_q.tm[g].field};
      assign xfer_o[g].req = state_q.tm[g].xreq;
      assign xfer_o[g].frame_start = state_q.tm[g].xframe;
      assign xfer_o[g].to_memory =
         state_q.ctrl[ML +: 2] != ftis_pkg::FTIS_MODE_DISPLAY;
      assign xfer_o[g].keep_outside =
         state_q.ctrl[ML +: 2] == ftis_pkg::FTIS_MODE_MERGE;
   end

   property p_pend_set;
      @(posedge clk_i) disable iff (rst_i)
      pend_set[0] |=> irq_o[0];
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("Timer 0 pending bit not set.");

   property p_irq_cause;
      @(posedge clk_i) disable iff (rst_i)
      $rose(irq_o[1]) |-> $past(pend_set[1]);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("Timer 1 request rose without its own event.");

   property p_service_gate;
      @(posedge clk_i) disable iff (rst_i)
      service_o |-> state_q.allow[0] &&
                    ((irq_o[0] && state_q.allow[1]) ||
                     (irq_o[1] && state_q.allow[2]));
   endproperty
   a_service_gate: assert property (p_service_gate)
      else $error("Service request without allow bits.");

   property p_irq_hold;
      @(posedge clk_i) disable iff (rst_i)
      irq_o[0] && !pend_clr[0] |=> irq_o[0];
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("Request dropped without a clear.");

   property p_cblank;
      @(posedge clk_i) disable iff (rst_i)
      video_o[0].cblank_n == !(video_o[0].hblank || video_o[0].vblank);
   endproperty
   a_cblank: assert property (p_cblank)
      else $error("Composite blank does not match blanks.");

   property p_tick_only;
      @(posedge clk_i) disable iff (rst_i)
      en[0] && !tick |=> $stable(state_q.tm[0].hcnt);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("Counter moved without a timing clock edge.");

   property p_one_field;
      @(posedge clk_i) disable iff (rst_i)
      !ilace ##1 !ilace |-> !state_q.tm[0].field;
   endproperty
   a_one_field: assert property (p_one_field)
      else $error("Field flag set while not interlaced.");

   property p_frame_xfer;
      @(posedge clk_i) disable iff (rst_i)
      xfer_o[0].frame_start |-> xfer_o[0].req;
   endproperty
   a_frame_xfer: assert property (p_frame_xfer)
      else $error("Frame start without transfer request.");

   property p_merge;
      @(posedge clk_i) disable iff (rst_i)
      xfer_o[0].keep_outside |-> xfer_o[0].to_memory;
   endproperty
   a_merge: assert property (p_merge)
      else $error("Merge mode not writing memory.");
endmodule

// *** testbench/ftis_far_end.sv ***
// Purpose: Far side model: timing clock source and transfer request tally.
// Assumes: The timing clock runs free with a 200 ns period.
// Notes: Phase is offset so it never lines up with the system clock.
`timescale 1ns/1ps
module ftis_far_end
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ftis_pkg::ftis_xfer_t [1:0] xfer_i,
   output logic video_timing_clock_o,
   output logic [1:0][7:0] req_cnt_o
);
   initial
   begin
      video_timing_clock_o = 1'b0;
      #7;
      forever #100 video_timing_clock_o = ~video_timing_clock_o;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         req_cnt_o <= '0;
      else
         for (int t = 0; t < 2; t++)
            req_cnt_o[t] <= req_cnt_o[t] + 8'(xfer_i[t].req);
   end
endmodule

// *** testbench/test_frame_timer_interrupt_and_sync.sv ***
// Purpose: Self-checking bench for the dual frame timer block.
// Assumes: Wishbone answers one cycle after a request is seen.
// Notes: Both timers use a 10 tick line and a 6 line frame.
`timescale 1ns/1ps
module test_frame_timer_interrupt_and_sync;
   logic clk_i, rst_i, vclk, cyc, stb, we, ack, service;
   logic [7:0] adr;
   logic [31:0] dat_w, dat_r, rd;
   logic [1:0] irq;
   logic [1:0][7:0] reqs;
   ftis_pkg::ftis_video_t [1:0] video;
   ftis_pkg::ftis_xfer_t [1:0] xfer;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   localparam logic [31:0] CFG [7] = '{32'h0001_0009, 32'h0008_0001,
      32'h0000_0005, 32'h0004_0000, 32'h0006_0002, 32'h0003_0001,
      32'h0005_0004};

   ftis_frame_timers uut (.clk_i(clk_i), .rst_i(rst_i),
      .video_timing_clock_i(vclk), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq), .service_o(service),
      .video_o(video), .xfer_o(xfer));

   ftis_far_end far (.clk_i(clk_i), .rst_i(rst_i), .xfer_i(xfer),
      .video_timing_clock_o(vclk), .req_cnt_o(reqs));

   initial clk_i = 1'b0;
   always #12.5 clk_i = ~clk_i;

   task stop_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_errors++;
         $display("BAD %0t timeout", $time);
         stop_test;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task wait_frame;
      do @(negedge clk_i); while (xfer[0].frame_start !== 1'b1);
   endtask

   task t_reset;
      foreach (CFG[i])
      begin
         wb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0, "reset or unmapped word");
      end
      wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
      wb(1'b0, 8'hFC, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      chk({30'h0, irq}, 32'h0, "irq after reset");
   endtask

   task t_frame;
      int nh, ns, nv, na;
      ftis_pkg::ftis_video_t p, c;
      for (int t = 0; t < 2; t++)
         foreach (CFG[i])
            wb(1'b1, 8'(32 * t + 32 + 4 * i), CFG[i]);
      wb(1'b1, ftis_pkg::FTIS_CTRL_OFS, 32'h01);
      wait_frame;
      nh = 0; ns = 0; nv = 0; na = 0;
      p = video[0];
      do
      begin
         @(negedge clk_i);
         c = video[0];
         nh += int'(c.hblank & ~p.hblank);
         ns += int'(c.hsync & ~p.hsync);
         nv += int'(c.vblank & ~p.vblank);
         na += int'(c.area & ~p.area);
         chk(c.cblank_n, !(c.hblank | c.vblank), "cblank");
         p = c;
      end
      while (xfer[0].frame_start !== 1'b1);
      chk(nh, 6, "hblank per frame");
      chk(ns, 6, "hsync per frame");
      chk(nv, 1, "vblank per frame");
      chk(na, 3, "area lines");
      chk(reqs[0] != 8'h0, 1, "t0 transfer requests");
      chk(reqs[1], 0, "t1 idle requests");
   endtask

   task t_irq;
      logic [31:0] al [4] = '{32'h0, 32'h100, 32'h101, 32'h201};
      logic ex [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
      while (irq[0] !== 1'b1) @(negedge clk_i);
      wb(1'b0, ftis_pkg::FTIS_PEND_OFS, 32'h0);
      chk(rd, 32'h0000_0100, "pending word");
      foreach (al[i])
      begin
         wb(1'b1, ftis_pkg::FTIS_ALLOW_OFS, al[i]);
         @(negedge clk_i);
         chk(service, ex[i], "service gate");
      end
      chk(irq, 2'b01, "request held");
      wb(1'b1, ftis_pkg::FTIS_PEND_OFS, 32'h0000_0100);
      repeat (2) @(negedge clk_i);
      chk({irq, service}, 3'b000, "request cleared");
   endtask

   task t_modes;
      logic [1:0] m;
      for (int i = 0; i < 3; i++)
      begin
         m = 2'(i);
         wb(1'b1, ftis_pkg::FTIS_CTRL_OFS, {24'h0, m, m, 4'h1});
         @(negedge clk_i);
         chk({xfer[0].to_memory, xfer[0].keep_outside, xfer[1].to_memory,
            xfer[1].keep_outside}, {m != 0, m == 2, m != 0, m == 2},
            "mode");
      end
   endtask

   task t_lock;
      wb(1'b1, ftis_pkg::FTIS_CTRL_OFS, 32'h07);
      wait_frame;
      wait_frame;
      chk(xfer[1].frame_start, 1'b1, "locked frame start");
      chk(reqs[1] != 8'h0, 1, "t1 transfer requests");
   endtask

   task t_ilace;
      logic f;
      int nv;
      ftis_pkg::ftis_video_t p;
      wb(1'b1, ftis_pkg::FTIS_CTRL_OFS, 32'h09);
      wait_frame;
      f = video[0].field;
      p = video[0];
      nv = 0;
      do
      begin
         @(negedge clk_i);
         nv += int'(video[0].vblank & ~p.vblank);
         p = video[0];
      end
      while (xfer[0].frame_start !== 1'b1);
      chk(nv, 1, "vblank per field");
      chk(video[0].field, !f, "field toggles");
      wb(1'b1, ftis_pkg::FTIS_CTRL_OFS, 32'h01);
      wait_frame;
      chk(video[0].field, 0, "one field");
   endtask

   initial
   begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      dat_w = 32'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_frame;
      t_irq;
      t_modes;
      t_lock;
      t_ilace;
      stop_test;
   end
endmodule
